// >>> src/rcdc_pkg.sv
// Package for the calendar date counters: register offsets, field positions and limits.
package rcdc_pkg;

   // ==========================================================
   // Register offsets on the internal I/O bus.
   localparam logic [7:0] ADDR_DAY    = 8'he4;
   localparam logic [7:0] ADDR_PERIOD = 8'he5;
   localparam logic [7:0] ADDR_YEAR   = 8'he6;
   localparam logic [7:0] ADDR_HUNDR  = 8'he7;

   // ==========================================================
   // Field positions of the packed decimal digits.
   localparam int TENS_MSB = 7;
   localparam int TENS_LSB = 4;
   localparam int ONES_MSB = 3;
   localparam int ONES_LSB = 0;

   // ==========================================================
   // Count limits in binary; decimal limits are derived from these.
   localparam logic [7:0] DAY_FIRST    = 8'h01;
   localparam logic [7:0] DAY_MAX      = 8'h1f;
   localparam logic [7:0] PERIOD_FIRST = 8'h01;
   localparam logic [7:0] PERIOD_MAX   = 8'h0c;
   localparam logic [7:0] YEAR_MAX     = 8'h63;
   localparam logic [7:0] FEB_NUM      = 8'h02;
   localparam logic [7:0] DAYS_LONG    = 8'h1f;
   localparam logic [7:0] DAYS_SHORT   = 8'h1e;
   localparam logic [7:0] DAYS_FEB     = 8'h1c;
   localparam logic [7:0] DAYS_FEB_LP  = 8'h1d;

   // Host bus request carried as one bundle.
   typedef struct packed {
      logic       rd;
      logic       wr;
      logic [7:0] addr;
      logic [7:0] wdata;
   } rcdc_req_t;

   // Four calendar counts, always stored in binary.
   typedef struct packed {
      logic [7:0] day;
      logic [7:0] period;
      logic [7:0] year;
      logic [7:0] hundr;
   } rcdc_cal_t;

endpackage : rcdc_pkg

// >>> src/rcdc_top.sv
// Calendar date counters: day of month, month, year and century with host access.
`timescale 1ns/1ps
`default_nettype none
module rcdc_top
   import rcdc_pkg::*;
(
   input  wire logic       CLK,
   input  wire logic       RST_N,
   input  wire logic       IO_RD,
   input  wire logic       IO_WR,
   input  wire logic [7:0] IO_ADDR,
   input  wire logic [7:0] IO_WDATA,
   input  wire logic       EDIT_PERMIT,
   input  wire logic       FORMAT_DEC,
   input  wire logic       DAY_CARRY,
   output var  logic [7:0] IO_RDATA,
   output var  logic       IO_HIT,
   output var  logic       CENTURY_CARRY
);

   // ==========================================================
   // Conversion helpers between stored binary and packed decimal, and the month length lookup.
   function automatic logic [7:0] to_dec(input logic [7:0] b);
      logic [7:0] t;
      t = 8'h00;
      t = b / 8'h0a;
      return {t[3:0], 4'((b % 8'h0a))};
   endfunction : to_dec

   function automatic logic [7:0] from_dec(input logic [7:0] d);
      return 8'((d[TENS_MSB:TENS_LSB] * 8'h0a) + {4'h0, d[ONES_MSB:ONES_LSB]});
   endfunction : from_dec

   function automatic logic [7:0] last_day(input logic [7:0] m, input logic [7:0] y);
      logic leap;
      leap = (y[1:0] == 2'b00);
      if (m == FEB_NUM) begin
         return leap ? DAYS_FEB_LP : DAYS_FEB;
      end else if (m == 8'h04 || m == 8'h06 || m == 8'h09 || m == 8'h0b) begin
         return DAYS_SHORT;
      end
      return DAYS_LONG;
   endfunction : last_day

   // ==========================================================
   // Calendar state and host answer.
   rcdc_req_t  req;
   rcdc_cal_t  cal;
   rcdc_cal_t  next_cal;
   logic [7:0] next_rdata;
   logic       next_hit;
   logic       next_carry;
   logic [7:0] wval;
   logic       dec_now;

   assign req     = '{rd: IO_RD, wr: IO_WR, addr: IO_ADDR, wdata: IO_WDATA};
   assign dec_now = FORMAT_DEC;

   // Next calendar value: host write while unlocked, else counting while locked.
   always_comb begin
      next_cal   = cal;
      next_carry = 1'b0;
      wval       = dec_now ? from_dec(req.wdata) : req.wdata;
      if (EDIT_PERMIT) begin
         if (req.wr) begin
            case (req.addr)
               ADDR_DAY:    next_cal.day    = wval;
               ADDR_PERIOD: next_cal.period = wval;
               ADDR_YEAR:   next_cal.year   = wval;
               ADDR_HUNDR:  next_cal.hundr  = wval;
               default:     next_cal        = cal;
            endcase
         end
      end else if (DAY_CARRY) begin
         if (cal.day >= last_day(cal.period, cal.year)) begin
            next_cal.day = DAY_FIRST;
            if (cal.period >= PERIOD_MAX) begin
               next_cal.period = PERIOD_FIRST;
               if (cal.year >= YEAR_MAX) begin
                  next_cal.year = 8'h00;
                  if (cal.hundr >= YEAR_MAX) begin
                     next_cal.hundr = 8'h00;
                     next_carry     = 1'b1;
                  end else begin
                     next_cal.hundr = cal.hundr + 8'h01;
                  end
               end else begin
                  next_cal.year = cal.year + 8'h01;
               end
            end else begin
               next_cal.period = cal.period + 8'h01;
            end
         end else begin
            next_cal.day = cal.day + 8'h01;
         end
      end
   end

   // Read data mux, always permitted regardless of the lock.
   always_comb begin
      next_hit   = 1'b1;
      next_rdata = 8'h00;
      case (req.addr)
         ADDR_DAY:    next_rdata = dec_now ? to_dec(cal.day) : cal.day;
         ADDR_PERIOD: next_rdata = dec_now ? to_dec(cal.period) : cal.period;
         ADDR_YEAR:   next_rdata = dec_now ? to_dec(cal.year) : cal.year;
         ADDR_HUNDR:  next_rdata = dec_now ? to_dec(cal.hundr) : cal.hundr;
         default:     next_hit   = 1'b0;
      endcase
      if (!req.rd) begin
         next_hit   = 1'b0;
         next_rdata = 8'h00;
      end
   end

   // Calendar flops carry no reset so that the date survives it.
   always_ff @(posedge CLK) begin
      cal <= next_cal;
   end

   // Bus answer and carry flops are reset for defined outputs.
   always_ff @(posedge CLK) begin
      if (!RST_N) begin
         IO_RDATA      <= 8'h00;
         IO_HIT        <= 1'b0;
         CENTURY_CARRY <= 1'b0;
      end else begin
         IO_RDATA      <= next_rdata;
         IO_HIT        <= next_hit;
         CENTURY_CARRY <= next_carry;
      end
   end

   // ==========================================================
   // Assertions.
   sequence s_locked_write;
      !EDIT_PERMIT && IO_WR && !DAY_CARRY;
   endsequence

   // Stability is asked for rather than equality, because the date holds no value until the
   // host first writes it, and an unwritten field must not trip the check.
   property p_lock_blocks;
      @(posedge CLK) disable iff (!RST_N) s_locked_write |=> $stable(cal);
   endproperty
   a_lock_blocks: assert property (p_lock_blocks) else $error("locked write changed calendar");

   property p_day_wr;
      @(posedge CLK) disable iff (!RST_N)
         EDIT_PERMIT && IO_WR && IO_ADDR == ADDR_DAY && !FORMAT_DEC |=> cal.day == $past(IO_WDATA);
   endproperty
   a_day_wr: assert property (p_day_wr) else $error("unlocked day write lost");

   property p_hold_unlocked;
      @(posedge CLK) disable iff (!RST_N) EDIT_PERMIT && !IO_WR |=> $stable(cal);
   endproperty
   a_hold_unlocked: assert property (p_hold_unlocked) else $error("count moved unlocked");

   property p_day_wrap;
      @(posedge CLK) disable iff (!RST_N)
         !EDIT_PERMIT && DAY_CARRY && cal.day == DAYS_LONG && cal.period == 8'h01
         |=> cal.day == DAY_FIRST && cal.period == 8'h02;
   endproperty
   a_day_wrap: assert property (p_day_wrap) else $error("day wrap wrong");

   property p_feb_leap;
      @(posedge CLK) disable iff (!RST_N)
         !EDIT_PERMIT && DAY_CARRY && cal.period == FEB_NUM && cal.day == DAYS_FEB
         && cal.year[1:0] == 2'b00 |=> cal.day == DAYS_FEB_LP;
   endproperty
   a_feb_leap: assert property (p_feb_leap) else $error("leap day skipped");

   property p_year_wrap;
      @(posedge CLK) disable iff (!RST_N)
         !EDIT_PERMIT && DAY_CARRY && cal.day == DAYS_LONG && cal.period == PERIOD_MAX
         && cal.year == YEAR_MAX && cal.hundr < YEAR_MAX
         |=> cal.year == 8'h00 && cal.hundr == $past(cal.hundr) + 8'h01;
   endproperty
   a_year_wrap: assert property (p_year_wrap) else $error("century not advanced");

   property p_dec_read;
      @(posedge CLK) disable iff (!RST_N)
         IO_RD && FORMAT_DEC && IO_ADDR == ADDR_DAY && cal.day == 8'h1f
         |=> IO_RDATA == 8'h31 && IO_HIT;
   endproperty
   a_dec_read: assert property (p_dec_read) else $error("decimal day read wrong");

   property p_bin_read;
      @(posedge CLK) disable iff (!RST_N)
         IO_RD && !FORMAT_DEC && IO_ADDR == ADDR_YEAR |=> IO_RDATA == $past(cal.year);
   endproperty
   a_bin_read: assert property (p_bin_read) else $error("binary year read wrong");

   // The very last day of century 99, year 99, wraps the date to day 1, month 1, year 0, century 0 and pulses the carry once.
   property p_century_carry;
      @(posedge CLK) disable iff (!RST_N)
         !EDIT_PERMIT && DAY_CARRY && cal.day == DAYS_LONG && cal.period == PERIOD_MAX
         && cal.year == YEAR_MAX && cal.hundr == YEAR_MAX
         |=> CENTURY_CARRY && cal.hundr == 8'h00;
   endproperty
   a_century_carry: assert property (p_century_carry) else $error("century wrap lost");

   // Without a read the answer lines return to zero, so stale data never looks valid.
   property p_idle_answer;
      @(posedge CLK) disable iff (!RST_N) !IO_RD |=> !IO_HIT && IO_RDATA == 8'h00;
   endproperty
   a_idle_answer: assert property (p_idle_answer) else $error("answer without read");

   // A packed decimal write is stored as its binary equivalent.
   property p_dec_write;
      @(posedge CLK) disable iff (!RST_N)
         EDIT_PERMIT && IO_WR && FORMAT_DEC && IO_ADDR == ADDR_YEAR && IO_WDATA == 8'h47
         |=> cal.year == 8'h2f;
   endproperty
   a_dec_write: assert property (p_dec_write) else $error("decimal year write wrong");

endmodule : rcdc_top
`default_nettype wire

// >>> dv/rcdc_host.sv
// Host processor model issuing single-byte I/O cycles to the calendar registers.
`timescale 1ns/1ps
`default_nettype none
module rcdc_host (
   input  wire logic       clk,
   output var  logic       io_rd,
   output var  logic       io_wr,
   output var  logic [7:0] io_addr,
   output var  logic [7:0] io_wdata,
   input  wire logic [7:0] io_rdata,
   input  wire logic       io_hit
);
   // ==========================================================
   // Bus idle state at time zero.
   initial begin
      io_rd = 1'b0;
      io_wr = 1'b0;
      io_addr = 8'h00;
      io_wdata = 8'h00;
   end

   // One write; released lines show the inverse so stale data is never mistaken for valid.
   task automatic wr(input logic [7:0] a, input logic [7:0] dat);
      @(negedge clk);
      io_wr = 1'b1;
      io_addr = a;
      io_wdata = dat;
      @(negedge clk);
      io_wr = 1'b0;
      io_addr = ~a;
      io_wdata = ~dat;
   endtask : wr

   // One read; the answer is registered, so it is taken one edge after the request.
   task automatic rd(input logic [7:0] a, output logic [7:0] dat, output logic hit);
      @(negedge clk);
      io_rd = 1'b1;
      io_addr = a;
      @(negedge clk);
      io_rd = 1'b0;
      io_addr = ~a;
      dat = io_rdata;
      hit = io_hit;
   endtask : rd
endmodule : rcdc_host
`default_nettype wire

// >>> dv/testbench.sv
// Self-checking testbench for the calendar date counters.
`timescale 1ns/1ps
`default_nettype none
module testbench import rcdc_pkg::*;;
   logic       clk = 1'b0;
   logic       rst_n;
   logic       edit;
   logic       fmt;
   logic       carry;
   logic       rd;
   logic       wr;
   logic [7:0] addr;
   logic [7:0] wdata;
   logic [7:0] rdata;
   logic       hit;
   logic       cent_pulse;
   logic [7:0] d;
   logic       h;
   int         err_total;
   int         n_compared;
   int         m;
   int         y;

   rcdc_top i_rcdc_top (.CLK(clk), .RST_N(rst_n), .IO_RD(rd), .IO_WR(wr), .IO_ADDR(addr),
      .IO_WDATA(wdata), .EDIT_PERMIT(edit), .FORMAT_DEC(fmt), .DAY_CARRY(carry),
      .IO_RDATA(rdata), .IO_HIT(hit), .CENTURY_CARRY(cent_pulse));
   rcdc_host i_rcdc_host (.clk(clk), .io_rd(rd), .io_wr(wr), .io_addr(addr),
      .io_wdata(wdata), .io_rdata(rdata), .io_hit(hit));

   // ==========================================================
   // Expectations, comparison and closing.
   // Last day of a month; leap years are every fourth year of the two-digit count.
   function automatic int last_day(input int mo, input int yy);
      if (mo == 2) return (yy % 4 == 0) ? 29 : 28;
      return (mo == 4 || mo == 6 || mo == 9 || mo == 11) ? 30 : 31;
   endfunction : last_day

   task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
      n_compared++;
      if (g !== e) begin
         err_total++;
         $display("BAD %s expected %h seen %h", nm, e, g);
      end
   endtask : chk

   task automatic rchk(input string nm, input logic [7:0] a, input logic [7:0] e);
      i_rcdc_host.rd(a, d, h);
      chk(nm, e, d);
      chk({nm, " hit"}, 8'h01, {7'h00, h});
   endtask : rchk

   // Unlock, write the date in binary, then lock again so counting resumes.
   task automatic set_date(input int dd, input int mo, input int yy, input int cc);
      edit = 1'b1;
      i_rcdc_host.wr(ADDR_DAY, 8'(dd));
      i_rcdc_host.wr(ADDR_PERIOD, 8'(mo));
      i_rcdc_host.wr(ADDR_YEAR, 8'(yy));
      i_rcdc_host.wr(ADDR_HUNDR, 8'(cc));
      edit = 1'b0;
   endtask : set_date

   // One day carry; the century pulse is registered on the carry's edge.
   task automatic pulse(input logic [7:0] ecc);
      @(negedge clk);
      carry = 1'b1;
      @(negedge clk);
      carry = 1'b0;
      chk("century carry", ecc, {7'h00, cent_pulse});
   endtask : pulse

   task automatic final_report();
      $display("compared %0d mismatches %0d", n_compared, err_total);
      if (err_total == 0 && n_compared > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask : final_report

   // ==========================================================
   // Clock, watchdog and main sequence.
   initial begin
      forever #5 clk = ~clk;
   end

   // The tests need well under a thousand cycles; five thousand means a hang.
   initial begin
      #50000;
      err_total++;
      final_report();
   end

   initial begin
      rst_n = 1'b0;
      edit = 1'b0;
      fmt = 1'b0;
      carry = 1'b0;
      m = $urandom(57994);
      repeat (8) @(negedge clk);
      rst_n = 1'b1;
      set_date(31, 12, 99, 99);
      rchk("day", ADDR_DAY, 8'h1f);
      rchk("month", ADDR_PERIOD, 8'h0c);
      rchk("year", ADDR_YEAR, 8'h63);
      rchk("century", ADDR_HUNDR, 8'h63);
      fmt = 1'b1;
      rchk("day dec", ADDR_DAY, 8'h31);
      rchk("month dec", ADDR_PERIOD, 8'h12);
      rchk("year dec", ADDR_YEAR, 8'h99);
      rchk("century dec", ADDR_HUNDR, 8'h99);
      i_rcdc_host.wr(ADDR_DAY, 8'h05);
      rchk("locked write", ADDR_DAY, 8'h31);
      edit = 1'b1;
      pulse(8'h00);
      rchk("day held", ADDR_DAY, 8'h31);
      edit = 1'b0;
      pulse(8'h01);
      rchk("day wrap", ADDR_DAY, 8'h01);
      rchk("month wrap", ADDR_PERIOD, 8'h01);
      rchk("year wrap", ADDR_YEAR, 8'h00);
      rchk("century wrap", ADDR_HUNDR, 8'h00);
      edit = 1'b1;
      i_rcdc_host.wr(ADDR_YEAR, 8'h47);
      edit = 1'b0;
      rst_n = 1'b0;
      repeat (2) @(negedge clk);
      rst_n = 1'b1;
      rchk("year after reset", ADDR_YEAR, 8'h47);
      i_rcdc_host.rd(8'he8, d, h);
      chk("unmapped data", 8'h00, d);
      chk("unmapped hit", 8'h00, {7'h00, h});
      fmt = 1'b0;
      // Corners: end of January, a leap February, and a year end that steps the century.
      set_date(31, 1, 24, 20);
      pulse(8'h00);
      rchk("january end", ADDR_PERIOD, 8'h02);
      set_date(28, 2, 24, 20);
      pulse(8'h00);
      rchk("leap day", ADDR_DAY, 8'h1d);
      set_date(31, 12, 99, 20);
      pulse(8'h00);
      rchk("year zero", ADDR_YEAR, 8'h00);
      rchk("century step", ADDR_HUNDR, 8'h15);
      // Random dates one day before month end, stepped across the boundary.
      repeat (12) begin
         m = $urandom_range(12, 1);
         y = $urandom_range(98, 0);
         set_date(last_day(m, y) - 1, m, y, 20);
         pulse(8'h00);
         rchk("last day", ADDR_DAY, 8'(last_day(m, y)));
         pulse(8'h00);
         rchk("first day", ADDR_DAY, 8'h01);
         rchk("next month", ADDR_PERIOD, 8'((m % 12) + 1));
      end
      final_report();
   end
endmodule : testbench
`default_nettype wire
